// *** iapfc_pkg.sv ***
// Shared constants and types for the flash programming controller
package iapfc_pkg;

  localparam int unsigned ADDR_W = 8;

  // Register byte offsets, one aligned word each
  localparam logic [7:0] OFF_MODE_CTRL = 8'h00;
  localparam logic [7:0] OFF_KEY       = 8'h04;
  localparam logic [7:0] OFF_TBC       = 8'h08;
  localparam logic [7:0] OFF_ADDR_LO   = 8'h0C;
  localparam logic [7:0] OFF_ADDR_HI   = 8'h10;
  localparam logic [7:0] OFF_DATA_BASE = 8'h14;
  localparam logic [7:0] OFF_DATA_LAST = 8'h30;

  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [7:0] CHIP_KEY_VAL  = 8'h55;

  // Field positions of mode_control and program_time_and_buffer_control
  localparam int unsigned BIT_EN     = 7;
  localparam int unsigned MODE_HI    = 6;
  localparam int unsigned MODE_LO    = 4;
  localparam int unsigned BIT_UNLOCK = 3;
  localparam int unsigned BIT_WT     = 2;
  localparam int unsigned BIT_RDEN   = 1;
  localparam int unsigned BIT_RD     = 0;
  localparam int unsigned BIT_TSEL   = 1;
  localparam int unsigned BIT_CLR    = 0;

  typedef enum logic [2:0] {
    MODE_WRITE  = 3'b000,
    MODE_ERASE  = 3'b001,
    MODE_READ   = 3'b011,
    MODE_UNLOCK = 3'b110
  } iapfc_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CLEAR = 3'b001,
    ST_READ  = 3'b010,
    ST_PROG  = 3'b011,
    ST_TIME  = 3'b100
  } iapfc_state_t;

  // Unlock pattern for word1 low, word1 high, word2 low, word2 high, word3 low, word3 high
  localparam logic [7:0] UNLOCK_PAT [0:5] = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};

  // Erase and write durations counted in sub-clock periods, least times rounded up
  localparam int unsigned SUB_HZ       = 32768;
  localparam int unsigned ERASE_T0_US  = 3200;
  localparam int unsigned WRITE_T0_US  = 2200;
  localparam int unsigned ERASE_T1_US  = 3700;
  localparam int unsigned WRITE_T1_US  = 3000;
  localparam logic [7:0]  ERASE_T0_TICKS = 8'((ERASE_T0_US * SUB_HZ + 999999) / 1000000);
  localparam logic [7:0]  WRITE_T0_TICKS = 8'((WRITE_T0_US * SUB_HZ + 999999) / 1000000);
  localparam logic [7:0]  ERASE_T1_TICKS = 8'((ERASE_T1_US * SUB_HZ + 999999) / 1000000);
  localparam logic [7:0]  WRITE_T1_TICKS = 8'((WRITE_T1_US * SUB_HZ + 999999) / 1000000);

  localparam int unsigned UNLOCK_TIMER_CYCLES = 1024;
  localparam int unsigned BUF_DEPTH = 32;
  localparam int unsigned BUF_WIDTH = 16;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : iapfc_pkg

// *** iapfc_wbuf.sv ***
// Page write buffer: data array plus resettable tag bits, registered read
`timescale 1ns/1ps
`default_nettype none
module iapfc_wbuf #(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned WIDTH = 16,
  localparam int unsigned AW   = $clog2(DEPTH)
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             wtag,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata,
  output logic                  rtag
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [DEPTH-1:0] tag_q;

  always_ff @(posedge clk_sys)
  begin
    if (we)
      mem_q[waddr] <= wdata;
  end

  // Tags reset so an unfilled entry never reaches the flash
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tag_q <= '0;
      rdata <= '0;
      rtag  <= 1'b0;
    end
    else
    begin
      if (we)
        tag_q[waddr] <= wtag;
      rdata <= mem_q[raddr];
      rtag  <= tag_q[raddr];
    end
  end
endmodule : iapfc_wbuf
`default_nettype wire

// *** iapfc_ctrl.sv ***
// Flash programming controller top: AXI4-Lite registers and operation sequencer
`timescale 1ns/1ps
`default_nettype none
module iapfc_ctrl #(
  parameter int unsigned UNLOCK_CYCLES = iapfc_pkg::UNLOCK_TIMER_CYCLES
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic [iapfc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic      [1:0]                  s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [iapfc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic      [31:0]                 s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        sub_clk,
  output logic                             cpu_stall,
  output logic                             chip_reset,
  output logic                             flash_rd_req,
  input  wire logic                        flash_rd_ack,
  input  wire logic [15:0]                 flash_rd_data,
  output logic                             flash_busy,
  output logic                             flash_erase,
  output logic      [12:0]                 flash_addr,
  output logic      [15:0]                 flash_wdata,
  output logic                             flash_wstrobe
);
  import iapfc_pkg::*;

  logic              aw_hold_q, w_hold_q, wlane_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0]        wbyte_q;
  logic [2:0]        mode_q;
  logic              en_q, unl_q, wt_q, rden_q, rd_q, tsel_q, clr_q;
  logic [7:0]        key_q;
  logic [12:0]       addr_q;
  logic [7:0]        dat_q [0:7];
  iapfc_state_t      state_q, state_d;
  logic [5:0]        idx_q;
  logic [7:0]        tgt_q, tick_q;
  logic              sub_prev_q;
  logic [15:0]       tmr_q;
  logic [5:0]        seen_q;
  logic [15:0]       buf_rdata;
  logic              buf_rtag;

  // Write channel capture; address and data may arrive in either order
  wire aw_take   = s_axi_awvalid & s_axi_awready;
  wire w_take    = s_axi_wvalid & s_axi_wready;
  wire do_write  = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire aw_hold_d = (aw_hold_q | aw_take) & ~do_write;
  wire w_hold_d  = (w_hold_q | w_take) & ~do_write;
  wire ar_take   = s_axi_arvalid & s_axi_arready;
  wire rvalid_d  = ar_take | (s_axi_rvalid & ~s_axi_rready);

  wire [ADDR_W-1:0] wa = {awaddr_q[ADDR_W-1:2], 2'b00};
  wire [ADDR_W-1:0] ra = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  wire [7:0]        wd = wbyte_q;
  wire              wr_ok = do_write & wlane_q;

  wire hit_mode = (wa == OFF_MODE_CTRL);
  wire hit_key  = (wa == OFF_KEY);
  wire hit_tbc  = (wa == OFF_TBC);
  wire hit_alo  = (wa == OFF_ADDR_LO);
  wire hit_ahi  = (wa == OFF_ADDR_HI);
  wire hit_data = (wa >= OFF_DATA_BASE) && (wa <= OFF_DATA_LAST);
  wire w_mapped = hit_mode | hit_key | hit_tbc | hit_alo | hit_ahi | hit_data;
  wire [2:0] w_didx = 3'((wa - OFF_DATA_BASE) >> 2);

  wire r_data   = (ra >= OFF_DATA_BASE) && (ra <= OFF_DATA_LAST);
  wire [2:0] r_didx = 3'((ra - OFF_DATA_BASE) >> 2);
  wire [7:0] ctrl_byte = {en_q, mode_q, unl_q, wt_q, rden_q, rd_q};
  wire [7:0] tbc_byte  = {6'h00, tsel_q, clr_q};
  wire [7:0] ahi_byte  = {3'b000, addr_q[12:8]};
  wire r_mapped = (ra == OFF_MODE_CTRL) || (ra == OFF_KEY) || (ra == OFF_TBC) ||
                  (ra == OFF_ADDR_LO) || (ra == OFF_ADDR_HI) || r_data;
  wire [7:0] reg_rd = (ra == OFF_MODE_CTRL) ? ctrl_byte :
                      (ra == OFF_KEY)       ? key_q :
                      (ra == OFF_TBC)       ? tbc_byte :
                      (ra == OFF_ADDR_LO)   ? addr_q[7:0] :
                      (ra == OFF_ADDR_HI)   ? ahi_byte :
                      r_data                ? dat_q[r_didx] : RST_BYTE;

  // Initiate bits are only taken while nothing runs or is pending
  wire idle    = (state_q == ST_IDLE);
  wire quiet   = idle & ~wt_q & ~rd_q & ~clr_q & ~unl_q;
  wire wm      = wr_ok & hit_mode;
  wire [2:0] wmode = wd[MODE_HI:MODE_LO];
  wire all3    = wd[BIT_WT] & wd[BIT_RDEN] & wd[BIT_RD];
  wire wt_mode = (wmode == MODE_WRITE) || (wmode == MODE_ERASE);
  wire set_wt  = wm & wd[BIT_WT] & ~all3 & quiet & en_q & wt_mode;
  wire set_rd  = wm & wd[BIT_RD] & ~all3 & quiet & rden_q & (wmode == MODE_READ);
  wire set_unl = wm & wd[BIT_UNLOCK] & quiet & (wmode == MODE_UNLOCK);
  wire set_clr = wr_ok & hit_tbc & wd[BIT_CLR] & quiet;

  wire sub_rise  = sub_clk & ~sub_prev_q;
  wire time_done = (state_q == ST_TIME) && (tick_q == tgt_q);
  wire wt_clr    = time_done;
  wire rd_clr    = (state_q == ST_READ) && flash_rd_ack;
  wire clr_done  = (state_q == ST_CLEAR) && (idx_q[4:0] == 5'h1F);
  wire start_op  = idle && (state_d == ST_PROG);

  // Unlock procedure timer and pattern check
  wire unl_expire = unl_q && (tmr_q == 16'(UNLOCK_CYCLES - 1));
  wire pat_ok = (&seen_q) &&
                (dat_q[2] == UNLOCK_PAT[0]) && (dat_q[3] == UNLOCK_PAT[1]) &&
                (dat_q[4] == UNLOCK_PAT[2]) && (dat_q[5] == UNLOCK_PAT[3]) &&
                (dat_q[6] == UNLOCK_PAT[4]) && (dat_q[7] == UNLOCK_PAT[5]);
  wire en_set = unl_expire & pat_ok;
  wire en_clr = wm & ~wd[BIT_EN];

  // Buffer port: clearing walks all entries, otherwise a high byte write loads a word
  wire       load_word = wr_ok & hit_data & (w_didx == 3'd1) & idle & en_q;
  wire       in_clear  = (state_q == ST_CLEAR);
  wire       buf_we    = in_clear | load_word;
  wire [4:0] buf_waddr = in_clear ? idx_q[4:0] : addr_q[4:0];
  wire [15:0] buf_wdata = in_clear ? 16'h0000 : {wd, dat_q[0]};
  wire       addr_step = load_word & (addr_q[4:0] != 5'h1F);
  wire       data_wr   = wr_ok & hit_data & idle;

  wire [7:0] tgt_sel = (mode_q == MODE_ERASE) ?
                       (tsel_q ? ERASE_T1_TICKS : ERASE_T0_TICKS) :
                       (tsel_q ? WRITE_T1_TICKS : WRITE_T0_TICKS);
  wire running_d = (state_d == ST_READ) || (state_d == ST_PROG) || (state_d == ST_TIME);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (clr_q)
          state_d = ST_CLEAR;
        else if (wt_q)
          state_d = ST_PROG;
        else if (rd_q)
          state_d = ST_READ;
      ST_CLEAR:
        if (idx_q[4:0] == 5'h1F)
          state_d = ST_IDLE;
      ST_READ:
        if (flash_rd_ack)
          state_d = ST_IDLE;
      ST_PROG:
        if (idx_q == 6'h20)
          state_d = ST_TIME;
      ST_TIME:
        if (time_done)
          state_d = ST_CLEAR;
      default:
        state_d = ST_IDLE;
    endcase
  end

  // Bus handshakes
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= '0;
      wbyte_q       <= RST_BYTE;
      wlane_q       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      aw_hold_q     <= aw_hold_d;
      w_hold_q      <= w_hold_d;
      s_axi_awready <= ~aw_hold_d;
      s_axi_wready  <= ~w_hold_d;
      if (aw_take)
        awaddr_q <= s_axi_awaddr;
      if (w_take)
      begin
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_rvalid  <= rvalid_d;
      s_axi_arready <= ~rvalid_d;
      if (ar_take)
      begin
        s_axi_rdata <= {24'h000000, reg_rd};
        s_axi_rresp <= r_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Control and status bits; a hardware set always wins over a clear
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= 3'b000;
      en_q   <= 1'b0;
      unl_q  <= 1'b0;
      wt_q   <= 1'b0;
      rden_q <= 1'b0;
      rd_q   <= 1'b0;
      tsel_q <= 1'b0;
      clr_q  <= 1'b0;
      key_q  <= RST_BYTE;
      tmr_q  <= 16'h0000;
      seen_q <= 6'h00;
    end
    else
    begin
      if (wm)
      begin
        mode_q <= wmode;
        rden_q <= wd[BIT_RDEN];
      end
      en_q  <= en_set | (en_q & ~en_clr);
      unl_q <= set_unl | (unl_q & ~unl_expire);
      wt_q  <= set_wt | (wt_q & ~wt_clr);
      rd_q  <= set_rd | (rd_q & ~rd_clr);
      clr_q <= set_clr | (clr_q & ~clr_done);
      if (wr_ok && hit_tbc && quiet)
        tsel_q <= wd[BIT_TSEL];
      if (wr_ok && hit_key)
        key_q <= wd;
      tmr_q <= unl_q ? 16'(tmr_q + 16'h0001) : 16'h0000;
      if (set_unl)
        seen_q <= 6'h00;
      else if (unl_q && data_wr && (w_didx >= 3'd2))
        seen_q[3'(w_didx - 3'd2)] <= 1'b1;
    end
  end

  // Address pair and data byte registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      addr_q <= 13'h0000;
      for (int i = 0; i < 8; i++)
        dat_q[i] <= RST_BYTE;
    end
    else
    begin
      if (wr_ok && hit_alo && idle)
        addr_q[7:0] <= wd;
      else if (wr_ok && hit_ahi && idle)
        addr_q[12:8] <= wd[4:0];
      else if (addr_step)
        addr_q <= 13'(addr_q + 13'h0001);
      if (data_wr)
        dat_q[w_didx] <= wd;
      else if (rd_clr)
      begin
        dat_q[0] <= flash_rd_data[7:0];
        dat_q[1] <= flash_rd_data[15:8];
      end
    end
  end

  // Sequencer: page walk, timed busy, then the buffer is cleared again
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q    <= ST_IDLE;
      idx_q      <= 6'h00;
      tgt_q      <= 8'h00;
      tick_q     <= 8'h00;
      sub_prev_q <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      sub_prev_q <= sub_clk;
      if (state_d != state_q)
        idx_q <= 6'h00;
      else if (in_clear || (state_q == ST_PROG))
        idx_q <= 6'(idx_q + 6'h01);
      if (start_op)
        tgt_q <= tgt_sel;
      if (state_q != ST_TIME)
        tick_q <= 8'h00;
      else if (sub_rise)
        tick_q <= 8'(tick_q + 8'h01);
    end
  end

  // Outputs toward the CPU, chip reset logic and flash array
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cpu_stall     <= 1'b0;
      chip_reset    <= 1'b0;
      flash_rd_req  <= 1'b0;
      flash_busy    <= 1'b0;
      flash_erase   <= 1'b0;
      flash_addr    <= 13'h0000;
      flash_wdata   <= 16'h0000;
      flash_wstrobe <= 1'b0;
    end
    else
    begin
      cpu_stall     <= running_d;
      chip_reset    <= wr_ok & hit_key & (wd == CHIP_KEY_VAL);
      flash_rd_req  <= (state_d == ST_READ);
      flash_busy    <= (state_d == ST_PROG) || (state_d == ST_TIME);
      if (start_op)
        flash_erase <= (mode_q == MODE_ERASE);
      else if (time_done)
        flash_erase <= 1'b0;
      flash_addr    <= (state_q == ST_PROG) ?
                       {addr_q[12:5], 5'(idx_q[4:0] - 5'h01)} : addr_q;
      flash_wdata   <= buf_rdata;
      // Only tagged entries reach the array; this is also how erase picks its words
      flash_wstrobe <= (state_q == ST_PROG) && (idx_q != 6'h00) && buf_rtag;
    end
  end

  iapfc_wbuf #(
    .DEPTH (BUF_DEPTH),
    .WIDTH (BUF_WIDTH)
  ) u_wbuf (
    .clk_sys (clk_sys),
    .rst     (rst),
    .we      (buf_we),
    .waddr   (buf_waddr),
    .wdata   (buf_wdata),
    .wtag    (~in_clear),
    .raddr   (idx_q[4:0]),
    .rdata   (buf_rdata),
    .rtag    (buf_rtag)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence rd_handshake;
    (state_q == ST_READ) && flash_rd_ack;
  endsequence

  sequence unlock_ok;
    unl_expire && pat_ok;
  endsequence

  chk_key_pulse: assert property (chip_reset == $past(wr_ok && hit_key && (wd == CHIP_KEY_VAL)))
    else $error("chip reset pulse does not match key write");
  chk_read_block: assert property ((wm && !rden_q && !rd_q) |=> !rd_q)
    else $error("read started while read enable was clear");
  chk_read_done: assert property (rd_handshake |=> !rd_q && (dat_q[0] == $past(flash_rd_data[7:0])))
    else $error("read completion did not clear bit or load data");
  chk_stall_ops: assert property ((state_q == ST_PROG) |-> cpu_stall ##1 (cpu_stall || state_q == ST_TIME))
    else $error("cpu not stalled during operation");
  chk_addr_inc: assert property ((load_word && addr_q[4:0] != 5'h1F) |=> addr_q == $past(addr_q) + 13'h0001)
    else $error("address did not increment on word load");
  chk_addr_sat: assert property ((load_word && addr_q[4:0] == 5'h1F) |=> $stable(addr_q))
    else $error("address moved past page end");
  chk_low_only: assert property ((data_wr && w_didx == 3'd0) |=> $stable(addr_q))
    else $error("low byte write changed address");
  chk_enable_ro: assert property ((wm && wd[BIT_EN] && !en_q && !unl_expire) |=> !en_q)
    else $error("software set the enabled bit");
  chk_unlock_end: assert property (unlock_ok |=> !unl_q && en_q)
    else $error("good unlock did not enable");
  chk_unlock_bad: assert property ((unl_expire && !pat_ok && !en_q) |=> !unl_q && !en_q)
    else $error("bad unlock handled wrongly");
  chk_time_sel0: assert property ((state_q == ST_TIME && !tsel_q) |->
      tgt_q == (flash_erase ? ERASE_T0_TICKS : WRITE_T0_TICKS))
    else $error("wrong duration for time select zero");
  chk_time_sel1: assert property ((state_q == ST_TIME && tsel_q) |->
      tgt_q == (flash_erase ? ERASE_T1_TICKS : WRITE_T1_TICKS))
    else $error("wrong duration for time select one");
  chk_wt_done: assert property ($fell(wt_q) |-> $past(state_q) == ST_TIME && $past(tick_q) == $past(tgt_q))
    else $error("write initiate cleared early");
  chk_clr_done: assert property ($fell(clr_q) |-> $past(state_q) == ST_CLEAR)
    else $error("buffer clear bit dropped outside clearing");

endmodule : iapfc_ctrl
`default_nettype wire

// *** test_iap_flash_program_control.sv ***
// Self-checking bench for the flash programming controller register and sequencer behaviour
`timescale 1ns/1ps
`default_nettype none
module test_iap_flash_program_control;
  import iapfc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awready, wready, bvalid, arready, rvalid, cpu_stall, chip_reset;
  logic [1:0]  bresp, rresp;
  logic        sub_clk = 1'b0, rd_req, rd_ack = 1'b0, busy, erase, wstrobe;
  logic [15:0] rd_data = 16'h0, fwdata;
  logic [12:0] faddr;
  logic [2:0]  sub_cnt = 3'h0;
  int          fails = 0, checks = 0, cyc = 0, strobes = 0, resets = 0, reqs = 0;
  iapfc_ctrl #(.UNLOCK_CYCLES(64)) DUT (.clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sub_clk(sub_clk), .cpu_stall(cpu_stall), .chip_reset(chip_reset),
    .flash_rd_req(rd_req), .flash_rd_ack(rd_ack), .flash_rd_data(rd_data),
    .flash_busy(busy), .flash_erase(erase), .flash_addr(faddr),
    .flash_wdata(fwdata), .flash_wstrobe(wstrobe));
  always #12.5 clk_sys = ~clk_sys;
  // Sub clock at one eighth of the system rate keeps the timed busy short in simulation
  // It runs steadily from time zero, so it is stable before any erase or write
  always @(posedge clk_sys)
  begin
    sub_cnt <= sub_cnt + 3'h1;
    sub_clk <= sub_cnt[2];
    rd_ack  <= rd_req & ~rd_ack;
    rd_data <= 16'hBEEF;
    strobes <= strobes + int'(wstrobe);
    resets  <= resets + int'(chip_reset);
    reqs    <= reqs + int'(rd_req);
    cyc     <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s got %h", $time, m, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    awaddr <= a; awvalid <= 1'b1; wdata <= {24'h0, d}; wvalid <= 1'b1; bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string m);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk({r, d[29:0]}, {RESP_OKAY, 22'h0, exp}, m);
  endtask : rchk
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rchk(OFF_TBC, 8'h00, "tbc reset");
    rchk(OFF_KEY, 8'h00, "key reset");
    rd(8'hFC, d, r);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0}, "unmapped read");
    wr(OFF_TBC, 8'hFE);
    rchk(OFF_TBC, 8'h02, "tbc upper bits");
    wr(OFF_TBC, 8'h00);
    wr(OFF_ADDR_HI, 8'hFF);
    rchk(OFF_ADDR_HI, 8'h1F, "addr high upper bits");
    wr(OFF_MODE_CTRL, 8'h80);
    rchk(OFF_MODE_CTRL, 8'h00, "enabled set by software");
    wr(OFF_KEY, 8'h54);
    repeat (4) @(posedge clk_sys);
    chk(resets, 0, "reset on wrong key");
    wr(OFF_KEY, 8'h55);
    repeat (4) @(posedge clk_sys);
    chk(resets, 1, "reset on key");
  endtask : t_regs
  task automatic t_unlock();
    wr(OFF_MODE_CTRL, 8'h68);
    for (int i = 0; i < 6; i++) wr(8'h1C + 8'(4 * i), UNLOCK_PAT[i]);
    // Procedure timer runs 64 cycles from the trigger
    repeat (70) @(posedge clk_sys);
    rchk(OFF_MODE_CTRL, 8'hE0, "unlock result");
  endtask : t_unlock
  task automatic wait_op(input int tgt, input string m);
    int   n, k, ticks;
    logic prev;
    n = 0;
    while (cpu_stall !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(cpu_stall, 1'b1, m);
    k = 0;
    ticks = 0;
    prev = sub_clk;
    // Rises during the 33-cycle page walk are not part of the timed busy
    while (cpu_stall === 1'b1 && k < 3000)
    begin
      @(posedge clk_sys);
      k++;
      if (k > 31 && sub_clk && !prev)
        ticks++;
      prev = sub_clk;
    end
    chk(ticks >= tgt && ticks <= tgt + 1, 1, m);
  endtask : wait_op
  task automatic t_write();
    wr(OFF_ADDR_LO, 8'h1E);
    wr(OFF_DATA_BASE, 8'h34);
    rchk(OFF_ADDR_LO, 8'h1E, "low byte moved address");
    wr(OFF_DATA_BASE + 8'h04, 8'h12);
    rchk(OFF_ADDR_LO, 8'h1F, "high byte increment");
    wr(OFF_DATA_BASE + 8'h04, 8'h56);
    rchk(OFF_ADDR_LO, 8'h1F, "address saturation");
    wr(OFF_MODE_CTRL, 8'h84);
    wait_op(WRITE_T0_TICKS, "write duration");
    chk(strobes, 2, "tagged words strobed");
    rchk(OFF_MODE_CTRL, 8'h80, "write initiate cleared");
  endtask : t_write
  task automatic t_erase();
    // Let the automatic buffer clear finish before the next operation
    repeat (40) @(posedge clk_sys);
    wr(OFF_ADDR_LO, 8'h00);
    wr(OFF_DATA_BASE + 8'h04, 8'hA5);
    rchk(OFF_ADDR_LO, 8'h01, "erase tag increment");
    wr(OFF_MODE_CTRL, 8'h94);
    wait_op(ERASE_T0_TICKS, "erase duration");
    chk(strobes, 3, "erase tagged words");
    // Blank check of the array itself is left to software
    rchk(OFF_MODE_CTRL, 8'h90, "erase initiate cleared");
  endtask : t_erase
  task automatic t_read();
    int n;
    repeat (40) @(posedge clk_sys);
    wr(OFF_MODE_CTRL, 8'h31);
    repeat (10) @(posedge clk_sys);
    chk(reqs, 0, "read without enable");
    wr(OFF_MODE_CTRL, 8'h32);
    wr(OFF_MODE_CTRL, 8'h33);
    repeat (20) @(posedge clk_sys);
    rchk(OFF_MODE_CTRL, 8'h32, "read initiate cleared");
    rchk(OFF_DATA_BASE, 8'hEF, "read low byte");
    rchk(OFF_DATA_BASE + 8'h04, 8'hBE, "read high byte");
    n = reqs;
    wr(OFF_MODE_CTRL, 8'h37);
    repeat (10) @(posedge clk_sys);
    chk(reqs, n, "read with all three bits");
    wr(OFF_TBC, 8'h01);
    repeat (40) @(posedge clk_sys);
    rchk(OFF_TBC, 8'h00, "buffer clear done");
  endtask : t_read
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_regs();
    t_unlock();
    t_write();
    t_erase();
    t_read();
    print_verdict();
  end
endmodule : test_iap_flash_program_control
`default_nettype wire
